// File: nsc_pkg.sv
// What this block does
// - Noise shaping can be switched on or off either from the dedicated enable pin or from register enable bits.
// - Unless overridden, the enable pin level alone decides shaping, whatever the register enable bits hold.
// - The register enable bits only take control once the pin override bit is set, which software sets first.
// - Two independent coefficient fields each give one corner, and the quiet band is centred midway between them.
// - Each 4-bit coefficient maps to a fixed normalized corner: 0 gives 0.25, 1-7 rise to 0.42, 8 gives 0, 9-f 0.08-0.23.
// - Suitable coefficients place the quiet band anywhere from zero up to 0.42 of the sampling rate.
package nsc_pkg;

  // ==========================================================
  // widths
  localparam int NSC_SAMPLE_W = 16;
  localparam int NSC_FRAC_W = 5;
  localparam int NSC_ACC_W = 18;
  localparam int NSC_COEF_W = 4;
  localparam int NSC_FREQ_W = 10;
  localparam int NSC_SUM_W = 11;
  localparam int NSC_COS_W = 12;
  localparam int NSC_COS_FRAC = 8;
  localparam int NSC_IDX_W = 5;
  localparam int NSC_ADDR_W = 12;
  localparam int NSC_DATA_W = 32;

  // ==========================================================
  // register map, byte addresses
  localparam logic [NSC_ADDR_W-1:0] NSC_OFS_CTRL = 12'h000;
  localparam logic [NSC_ADDR_W-1:0] NSC_OFS_COEF = 12'h004;
  localparam logic [NSC_ADDR_W-1:0] NSC_OFS_STATUS = 12'h008;
  localparam logic [NSC_ADDR_W-1:0] NSC_OFS_CORNER = 12'h00c;
  localparam logic [NSC_ADDR_W-1:0] NSC_OFS_CENTER = 12'h010;

  // field positions
  localparam int NSC_CTRL_OVERRIDE_BIT = 0;
  localparam int NSC_CTRL_EN_ONE_BIT = 1;
  localparam int NSC_CTRL_EN_TWO_BIT = 2;
  localparam int NSC_COEF_FIRST_LSB = 0;
  localparam int NSC_COEF_SECOND_LSB = 4;
  localparam int NSC_STAT_ACTIVE_BIT = 0;
  localparam int NSC_STAT_PIN_BIT = 1;
  localparam int NSC_STAT_SAT_BIT = 2;
  localparam int NSC_STAT_IDX_LSB = 8;
  localparam int NSC_CORNER_FIRST_LSB = 0;
  localparam int NSC_CORNER_SECOND_LSB = 16;

  // reset values
  localparam logic [NSC_COEF_W-1:0] NSC_COEF_RESET = 4'h0;

  // ==========================================================
  // corner lookup, thousandths of the sampling rate
  localparam logic [NSC_FREQ_W-1:0] NSC_CORNER_TABLE [0:15] = '{
    10'h0fa, 10'h10e, 10'h122, 10'h137,   // 250 270 290 311
    10'h14d, 10'h165, 10'h181, 10'h1a4,   // 333 357 385 420
    10'h000, 10'h050, 10'h073, 10'h08f,   // 0 80 115 143
    10'h0a7, 10'h0bd, 10'h0d2, 10'h0e6    // 167 189 210 230
  };

  // centre to notch index: idx = (sum * steps + half) / scale
  localparam logic [15:0] NSC_FREQ_SCALE = 16'h03e8;
  localparam logic [15:0] NSC_FREQ_HALF = 16'h01f4;
  localparam int NSC_COS_STEPS_LOG2 = 4;

  // 2*cos(2*pi*k/32) for k = 0..16, q4.8 signed, spans 0 to fs/2
  localparam logic signed [NSC_COS_W-1:0] NSC_COS_TABLE [0:16] = '{
    12'h200, 12'h1f6, 12'h1d9, 12'h1aa, 12'h16a, 12'h11c, 12'h0c4, 12'h064, 12'h000,
    12'hf9c, 12'hf3c, 12'hee4, 12'he96, 12'he56, 12'he27, 12'he0a, 12'he00
  };

  // output saturation bounds on the coarse grid
  localparam logic signed [NSC_ACC_W-1:0] NSC_Q_MAX = 18'h07fe0;
  localparam logic signed [NSC_ACC_W-1:0] NSC_Q_MIN = 18'h38000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic signed [NSC_SAMPLE_W-1:0] data;
  } nsc_sample_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [NSC_ADDR_W-1:0] paddr;
    logic [NSC_DATA_W-1:0] pwdata;
  } nsc_apb_req_t;

  typedef struct packed {
    logic override_pin;
    logic enable_bit_one;
    logic enable_bit_two;
  } nsc_ctrl_t;

endpackage

// File: nsc_sync.sv
`timescale 1ns/1ps
module nsc_sync (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // level in and out
  input wire logic i_d,
  output logic o_q
);
  // ==========================================================
  // two stage synchroniser, first stage feeds only the second
  logic stage_one;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage_one <= 1'b0;
      o_q <= 1'b0;
    end else begin
      stage_one <= i_d;
      o_q <= stage_one;
    end
  end
endmodule

// File: nsc_corner_map.sv
`timescale 1ns/1ps
module nsc_corner_map
  import nsc_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // coefficient in, corner out
  input wire logic [nsc_pkg::NSC_COEF_W-1:0] i_code,
  output logic [nsc_pkg::NSC_FREQ_W-1:0] o_corner
);
  // ==========================================================
  // registered lookup, code 8 is the zero corner
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_corner <= NSC_CORNER_TABLE[NSC_COEF_RESET];
    end else begin
      o_corner <= NSC_CORNER_TABLE[i_code];
    end
  end
endmodule

// File: nsc_top.sv
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module nsc_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // apb slave
  input wire nsc_pkg::nsc_apb_req_t i_apb,
  output logic [nsc_pkg::NSC_DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // shaping enable pin
  input wire logic i_shaping_enable_pin,
  // sample stream
  input wire nsc_pkg::nsc_sample_t i_sample,
  output nsc_pkg::nsc_sample_t o_sample,
  // status
  output logic o_shaping_active
);
  import nsc_pkg::*;

  // ==========================================================
  // reset release
  logic rst_n;

  // async assert, synchronous release
  nsc_sync u_reset_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_d(1'b1),
    .o_q(rst_n)
  );

  // ==========================================================
  // enable pin synchroniser
  logic pin_level;

  // pin comes from another domain, so two flops first
  nsc_sync u_pin_sync (
    .i_clock(i_clock),
    .i_resetn(rst_n),
    .i_d(i_shaping_enable_pin),
    .o_q(pin_level)
  );

  // ==========================================================
  // apb decode
  logic setup_phase;
  logic access_phase;
  logic addr_mapped;
  logic wr_ctrl;
  logic wr_coef;
  logic wr_status;

  assign setup_phase = i_apb.psel & ~i_apb.penable;
  assign access_phase = i_apb.psel & i_apb.penable;

  // word aligned hits only
  always_comb begin
    addr_mapped = 1'b0;
    if (i_apb.paddr[1:0] == 2'h0) begin
      addr_mapped = (i_apb.paddr == NSC_OFS_CTRL) | (i_apb.paddr == NSC_OFS_COEF) |
                    (i_apb.paddr == NSC_OFS_STATUS) | (i_apb.paddr == NSC_OFS_CORNER) |
                    (i_apb.paddr == NSC_OFS_CENTER);
    end
  end

  // writes land only at the access edge
  assign wr_ctrl = access_phase & i_apb.pwrite & (i_apb.paddr == NSC_OFS_CTRL);
  assign wr_coef = access_phase & i_apb.pwrite & (i_apb.paddr == NSC_OFS_COEF);
  assign wr_status = access_phase & i_apb.pwrite & (i_apb.paddr == NSC_OFS_STATUS);

  // ==========================================================
  // control register
  nsc_ctrl_t ctrl;

  // override and the two enable bits, all off after reset
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      ctrl.override_pin <= i_apb.pwdata[NSC_CTRL_OVERRIDE_BIT];
      ctrl.enable_bit_one <= i_apb.pwdata[NSC_CTRL_EN_ONE_BIT];
      ctrl.enable_bit_two <= i_apb.pwdata[NSC_CTRL_EN_TWO_BIT];
    end
  end

  // ==========================================================
  // coefficient register
  logic [NSC_COEF_W-1:0] first_corner_coefficient;
  logic [NSC_COEF_W-1:0] second_corner_coefficient;

  // fields are independent; taken live, so write them before enabling
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      first_corner_coefficient <= NSC_COEF_RESET;
      second_corner_coefficient <= NSC_COEF_RESET;
    end else if (wr_coef) begin
      first_corner_coefficient <= i_apb.pwdata[NSC_COEF_FIRST_LSB +: NSC_COEF_W];
      second_corner_coefficient <= i_apb.pwdata[NSC_COEF_SECOND_LSB +: NSC_COEF_W];
    end
  end

  // ==========================================================
  // corner frequencies and band centre
  logic [NSC_FREQ_W-1:0] first_corner;
  logic [NSC_FREQ_W-1:0] second_corner;
  logic [NSC_SUM_W-1:0] corner_sum;
  logic [15:0] idx_scaled;
  logic [NSC_IDX_W-1:0] notch_idx;
  logic signed [NSC_COS_W-1:0] notch_coef;

  nsc_corner_map u_first_map (
    .i_clock(i_clock),
    .i_resetn(rst_n),
    .i_code(first_corner_coefficient),
    .o_corner(first_corner)
  );

  nsc_corner_map u_second_map (
    .i_clock(i_clock),
    .i_resetn(rst_n),
    .i_code(second_corner_coefficient),
    .o_corner(second_corner)
  );

  // sum is twice the centre, so the notch sits midway between corners
  assign corner_sum = {1'b0, first_corner} + {1'b0, second_corner};
  assign idx_scaled = 16'(((16'(corner_sum) << NSC_COS_STEPS_LOG2) + NSC_FREQ_HALF) / NSC_FREQ_SCALE);

  // registered notch coefficient; table spans dc to half the sample rate
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      notch_idx <= '0;
      notch_coef <= '0;
    end else begin
      notch_idx <= idx_scaled[NSC_IDX_W-1:0];
      notch_coef <= NSC_COS_TABLE[notch_idx];
    end
  end

  // ==========================================================
  // shaping enable decision
  logic next_active;
  logic shaping_active;

  // pin rules unless the override hands control to the register bits
  always_comb begin
    if (ctrl.override_pin) begin
      next_active = ctrl.enable_bit_one | ctrl.enable_bit_two;
    end else begin
      next_active = pin_level;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      shaping_active <= 1'b0;
    end else begin
      shaping_active <= next_active;
    end
  end

  assign o_shaping_active = shaping_active;

  // ==========================================================
  // error feedback requantiser
  // noise transfer 1 - a z^-1 + z^-2 puts a zero at the band centre
  logic [NSC_FRAC_W-1:0] err1;
  logic [NSC_FRAC_W-1:0] err2;
  logic signed [NSC_ACC_W-1:0] fb_prod;
  logic signed [NSC_ACC_W-1:0] fb;
  logic signed [NSC_ACC_W-1:0] x_ext;
  logic signed [NSC_ACC_W-1:0] acc;
  logic sat_hi;
  logic sat_lo;
  logic signed [NSC_SAMPLE_W-1:0] quant;

  assign fb_prod = notch_coef * $signed({1'b0, err1});
  assign fb = (fb_prod >>> NSC_COS_FRAC) - $signed({{(NSC_ACC_W-NSC_FRAC_W){1'b0}}, err2});
  assign x_ext = NSC_ACC_W'(i_sample.data);
  assign acc = x_ext + fb;
  assign sat_hi = acc > NSC_Q_MAX;
  assign sat_lo = acc < NSC_Q_MIN;

  // clamp keeps the grid; low bits cleared to the coarse step
  always_comb begin
    if (sat_hi) begin
      quant = NSC_Q_MAX[NSC_SAMPLE_W-1:0];
    end else if (sat_lo) begin
      quant = NSC_Q_MIN[NSC_SAMPLE_W-1:0];
    end else begin
      quant = {acc[NSC_SAMPLE_W-1:NSC_FRAC_W], {NSC_FRAC_W{1'b0}}};
    end
  end

  // error history; cleared while off so a fresh enable starts clean
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      err1 <= '0;
      err2 <= '0;
    end else if (!shaping_active) begin
      err1 <= '0;
      err2 <= '0;
    end else if (i_sample.valid) begin
      err2 <= err1;
      // a clipped sample would feed back a huge error, so drop it
      err1 <= (sat_hi | sat_lo) ? '0 : acc[NSC_FRAC_W-1:0];
    end
  end

  // output sample, one cycle latency either way
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_sample <= '0;
    end else begin
      o_sample.valid <= i_sample.valid;
      if (i_sample.valid) begin
        o_sample.data <= shaping_active ? quant : i_sample.data;
      end
    end
  end

  // ==========================================================
  // saturation sticky flag
  logic sat_flag;
  logic sat_set;
  logic sat_clr;

  assign sat_set = shaping_active & i_sample.valid & (sat_hi | sat_lo);
  assign sat_clr = wr_status & i_apb.pwdata[NSC_STAT_SAT_BIT];

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sat_flag <= 1'b0;
    end else begin
      sat_flag <= sat_set | (sat_flag & ~sat_clr);
    end
  end

  // ==========================================================
  // read data and answer
  logic [NSC_DATA_W-1:0] next_rdata;
  logic slverr_q;

  always_comb begin
    next_rdata = '0;
    unique case (i_apb.paddr)
      NSC_OFS_CTRL: begin
        next_rdata[NSC_CTRL_OVERRIDE_BIT] = ctrl.override_pin;
        next_rdata[NSC_CTRL_EN_ONE_BIT] = ctrl.enable_bit_one;
        next_rdata[NSC_CTRL_EN_TWO_BIT] = ctrl.enable_bit_two;
      end
      NSC_OFS_COEF: begin
        next_rdata[NSC_COEF_FIRST_LSB +: NSC_COEF_W] = first_corner_coefficient;
        next_rdata[NSC_COEF_SECOND_LSB +: NSC_COEF_W] = second_corner_coefficient;
      end
      NSC_OFS_STATUS: begin
        next_rdata[NSC_STAT_ACTIVE_BIT] = shaping_active;
        next_rdata[NSC_STAT_PIN_BIT] = pin_level;
        next_rdata[NSC_STAT_SAT_BIT] = sat_flag;
        next_rdata[NSC_STAT_IDX_LSB +: NSC_IDX_W] = notch_idx;
      end
      NSC_OFS_CORNER: begin
        next_rdata[NSC_CORNER_FIRST_LSB +: NSC_FREQ_W] = first_corner;
        next_rdata[NSC_CORNER_SECOND_LSB +: NSC_FREQ_W] = second_corner;
      end
      NSC_OFS_CENTER: begin
        next_rdata[NSC_SUM_W-1:0] = corner_sum;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // captured at setup so read data comes from a flop in the access cycle
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_prdata <= '0;
      slverr_q <= 1'b0;
    end else if (setup_phase) begin
      o_prdata <= (addr_mapped & ~i_apb.pwrite) ? next_rdata : '0;
      slverr_q <= ~addr_mapped;
    end
  end

  // zero wait states; error only shown in the access phase
  assign o_pready = 1'b1;
  assign o_pslverr = access_phase & slverr_q;

endmodule

// File: nsc_pin_src.sv
`timescale 1ns/1ps
// ==========================================================
// far side: external logic that drives the shaping enable pin
module nsc_pin_src (
  // clock
  input wire logic i_clock,
  // requested level and pace
  input wire logic i_want,
  input wire logic i_slow,
  // pin level
  output logic o_pin
);
  logic held;

  // slow mode lags one more edge, so the pin synchroniser sees both paces
  always @(posedge i_clock) begin
    held <= i_want;
    o_pin <= i_slow ? held : i_want;
  end
endmodule

// File: nsc_top_chk.sv
`timescale 1ns/1ps
// ==========================================================
// port checker for the shaping control top
module nsc_top_chk
  import nsc_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // apb
  input wire nsc_pkg::nsc_apb_req_t i_apb,
  input wire logic [nsc_pkg::NSC_DATA_W-1:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // pin, samples, status
  input wire logic i_shaping_enable_pin,
  input wire nsc_pkg::nsc_sample_t i_sample,
  input wire nsc_pkg::nsc_sample_t o_sample,
  input wire logic o_shaping_active
);
  logic [2:0] sh;
  logic [2:0] age;
  logic acc;
  logic mapped;

  // access phase and decoded address
  assign acc = i_apb.psel && i_apb.penable;
  assign mapped = i_apb.paddr inside {NSC_OFS_CTRL, NSC_OFS_COEF, NSC_OFS_STATUS, NSC_OFS_CORNER, NSC_OFS_CENTER};

  // shadow of the control word, written on the access edge
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sh <= 3'h0;
    end else if (acc && o_pready && i_apb.pwrite && i_apb.paddr == NSC_OFS_CTRL) begin
      sh <= i_apb.pwdata[2:0];
    end
  end

  // edges since release; internal reset lags, so checks wait for a full count
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_ready_in_access: assert property (acc |-> o_pready)
    else $error("pready low in access phase");
  a_err_on_unmapped: assert property (acc && !mapped |-> o_pslverr && (i_apb.pwrite || o_prdata == '0))
    else $error("unmapped access not refused");
  a_err_only_unmapped: assert property (!(acc && !mapped) |-> !o_pslverr)
    else $error("spurious slave error");
  a_ctrl_readback: assert property (age == 3'h7 && acc && !i_apb.pwrite && i_apb.paddr == NSC_OFS_CTRL
    |-> o_prdata[2:0] == sh)
    else $error("control readback differs");
  a_bits_decide: assert property (age == 3'h7 && $past(sh[0]) |-> o_shaping_active == ($past(sh[1]) | $past(sh[2])))
    else $error("enable bits not obeyed under override");
  a_pin_decides: assert property (age == 3'h7 && !$past(sh[0]) |-> o_shaping_active == $past(i_shaping_enable_pin, 3))
    else $error("pin level not obeyed");
  a_valid_follows: assert property (age == 3'h7 && i_sample.valid |=> o_sample.valid)
    else $error("sample valid lost");
  a_data_holds: assert property (age == 3'h7 && !i_sample.valid |=> !o_sample.valid && $stable(o_sample.data))
    else $error("output changed without valid");
  a_pass_exact: assert property (age == 3'h7 && $past(i_sample.valid) && !$past(o_shaping_active)
    && !$past(o_shaping_active, 2) |-> o_sample.data == $past(i_sample.data))
    else $error("sample altered while shaping off");
  a_grid_active: assert property (age == 3'h7 && $past(i_sample.valid) && $past(o_shaping_active)
    |-> o_sample.data[4:0] == 5'h00)
    else $error("shaped sample off the coarse grid");

  c_by_bits: cover property (o_shaping_active && sh[0]);
  c_by_pin: cover property (o_shaping_active && !sh[0]);
  c_refused: cover property (o_pslverr);
endmodule

bind nsc_top nsc_top_chk u_chk (.i_clock(i_clock), .i_resetn(i_resetn), .i_apb(i_apb), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_shaping_enable_pin(i_shaping_enable_pin),
  .i_sample(i_sample), .o_sample(o_sample), .o_shaping_active(o_shaping_active));

// File: nsc_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the shaping control top
module nsc_top_tb;
  import nsc_pkg::*;
  logic clk;
  logic rstn;
  nsc_apb_req_t apb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_want;
  logic slow;
  logic pin;
  logic active;
  nsc_sample_t smp;
  nsc_sample_t osmp;
  nsc_sample_t sv;
  int n_mismatch;
  int check_count;
  int mode;
  int ex;
  int j;
  logic [15:0] q[$];
  logic [15:0] exp_d;
  logic [31:0] r;
  logic e;
  // sample stream waits for the internal reset release, else the first sample is swallowed
  logic run;
  // corner of each code, thousandths of the sampling rate
  int corner_k[16] = '{250, 270, 290, 311, 333, 357, 385, 420, 0, 80, 115, 143, 167, 189, 210, 230};

  nsc_top DUT (.i_clock(clk), .i_resetn(rstn), .i_apb(apb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_shaping_enable_pin(pin), .i_sample(smp), .o_sample(osmp), .o_shaping_active(active));
  nsc_pin_src u_pin (.i_clock(clk), .i_want(pin_want), .i_slow(slow), .o_pin(pin));

  // ==========================================================
  // clock, time-zero values, watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    apb = '0;
    smp = '0;
    pin_want = 1'b0;
    slow = 1'b0;
    run = 1'b0;
    mode = 0;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
    output logic er);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= w;
    apb.paddr <= a;
    apb.pwdata <= d;
    @(posedge clk);
    apb.penable <= 1'b1;
    // request stands until the edge that sees ready; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, want);
    chk({31'h0, e}, 32'h0);
  endtask

  function automatic logic [31:0] corners(input int a, input int b);
    return {6'h00, 10'(b), 6'h00, 10'(a)};
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // random sample stream and its model; no back-pressure, so every valid is queued
  always @(posedge clk) begin
    if (run) begin
      sv.valid = 1'($urandom_range(0, 1));
      sv.data = 16'($urandom);
      smp <= sv;
      if (sv.valid) q.push_back(sv.data);
    end
  end
  always @(negedge clk) begin
    if (osmp.valid === 1'b1 && q.size() > 0) begin
      exp_d = q.pop_front();
      if (mode == 1) chk({16'h0, osmp.data}, {16'h0, exp_d});
      if (mode == 2) chk({27'h0, osmp.data[4:0]}, 32'h0);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(5236));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b1;
    rd_chk(NSC_OFS_CTRL, 32'h0);
    rd_chk(NSC_OFS_CORNER, corners(corner_k[0], corner_k[0]));
    rd_chk(NSC_OFS_CENTER, 32'd500);
    // unmapped and unaligned places are refused with zero data
    xfer(1'b0, 12'h014, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    xfer(1'b0, 12'h002, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    // every code on both fields, including the zero corner and the top corner
    for (int k = 0; k < 16; k++) begin
      j = (k * 7 + 3) % 16;
      xfer(1'b1, NSC_OFS_COEF, 32'((j << 4) | k), r, e);
      rd_chk(NSC_OFS_COEF, 32'((j << 4) | k));
      rd_chk(NSC_OFS_CORNER, corners(corner_k[k], corner_k[j]));
      rd_chk(NSC_OFS_CENTER, 32'(corner_k[k] + corner_k[j]));
      // notch index is the centre rounded to 32 steps per sampling rate; pin low, shaping off
      rd_chk(NSC_OFS_STATUS, 32'((((corner_k[k] + corner_k[j]) * 16 + 500) / 1000) << NSC_STAT_IDX_LSB));
    end
    // shaping off: random coefficients must not touch the samples
    mode = 1;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, NSC_OFS_COEF, 32'($urandom_range(0, 255)), r, e);
      repeat (10) @(posedge clk);
    end
    // coefficients first, then every control word under both pin levels
    xfer(1'b1, NSC_OFS_COEF, 32'h0000002d, r, e);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        mode = 0;
        pin_want <= 1'(p);
        slow <= 1'(c % 2);
        xfer(1'b1, NSC_OFS_CTRL, 32'(c), r, e);
        rd_chk(NSC_OFS_CTRL, 32'(c));
        repeat (4) @(posedge clk);
        ex = (c % 2 == 1) ? ((c >> 1) != 0) : p;
        @(negedge clk);
        chk({31'h0, active}, 32'(ex));
        @(posedge clk);
        xfer(1'b0, NSC_OFS_STATUS, 32'h0, r, e);
        chk({31'h0, r[NSC_STAT_ACTIVE_BIT]}, 32'(ex));
        mode = (ex != 0) ? 2 : 1;
        repeat (12) @(posedge clk);
      end
    end
    mode = 0;
    complete_run();
  end
endmodule
